// ==== pkg/pia_map.svh ====
// Constants for the PCI sideband block: reset values.
`ifndef PIA_MAP_SVH
`define PIA_MAP_SVH
`define PIA_DIV_RESET 1'b0
`define PIA_SEL_RESET 1'b0
`define PIA_GNT_N_RESET 1'b1
`define PIA_CLK_EN_RESET 1'b0
`define PIA_REQ_N_RESET 1'b1
`define PIA_INT_N_RESET 1'b1
`define PIA_FRAME_N_RESET 1'b1
`endif

// ==== pkg/pia_pkg.sv ====
// Types for the PCI sideband block.
`default_nettype none
package pia_pkg;
  typedef enum logic [1:0] {
    MS_IDLE,
    MS_REQUEST,
    MS_FRAME
  } pia_master_state_type;
endpackage : pia_pkg
`default_nettype wire

// ==== src/pia_sync.sv ====
// Two flip-flop synchroniser for one asynchronous level.
`timescale 1ns/1ps
`default_nettype none
module pia_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1_q;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      stage1_q <= RESET_VALUE;
      syncOut <= RESET_VALUE;
    end
    else
    begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end
endmodule : pia_sync
`default_nettype wire

// ==== src/pia_sideband.sv ====
// PCI sideband: interrupt pins, bus request/grant and expansion clock select.
//
// Function
// - Drive first interrupt pin low while any protocol-layer interrupt is pending.
// - Drive second interrupt pin low while any expansion-bus interrupt is pending.
// - Assert own bus request to the arbiter when mastering is needed.
// - Start a cycle with frame only while the grant is held.
// - Select input low or open gives expansion clock equal to PCI clock.
// - Select input high gives expansion clock at half the PCI clock.
// - Interrupt, request, grant and frame pins are active low.
// - Drive frame from cycle start and hold it for the cycle's duration.
`timescale 1ns/1ps
`default_nettype none
`include "pia_map.svh"
module pia_sideband #(
  parameter int L2_SOURCES = 8,
  parameter int EXP_SOURCES = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [L2_SOURCES-1:0] l2IrqPending,
  input wire logic [EXP_SOURCES-1:0] expIrqPending,
  output logic intProtocol_n_o,
  output logic intProtocol_n_oe,
  output logic intExpansion_n_o,
  output logic intExpansion_n_oe,
  input wire logic masterWant,
  input wire logic masterLast,
  output logic busRequest_n,
  input wire logic busGrant_n,
  output logic frame_n_o,
  output logic frame_n_oe,
  output logic masterActive,
  input wire logic expansion_clock_halve_select,
  output logic expansion_bus_clock_en,
  output logic expansionHalfRate
);
  // An interrupt with no source at all could never be raised.
  if (L2_SOURCES < 1 || EXP_SOURCES < 1)
  begin : gBadSourceCount
    $error("pia_sideband: source counts must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs from outside the domain pass two flip-flops.
  logic grantSync;
  logic halveSync;

  pia_sync #(.RESET_VALUE(`PIA_GNT_N_RESET)) uGrantSync (
    .clk_sys(clk_sys),
    .reset(reset),
    .asyncIn(busGrant_n),
    .syncOut(grantSync)
  );

  pia_sync #(.RESET_VALUE(`PIA_SEL_RESET)) uHalveSync (
    .clk_sys(clk_sys),
    .reset(reset),
    .asyncIn(expansion_clock_halve_select),
    .syncOut(halveSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: open drain, low while pending. The pin is only ever pulled
  // low; the pull-up on the board restores the released level.
  logic intProtocol_n_q;
  logic intExpansion_n_q;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      intProtocol_n_q <= `PIA_INT_N_RESET;
    end
    else
    begin
      intProtocol_n_q <= ~(|l2IrqPending);
    end
  end

  // The expansion interrupt has its own register, so neither source can hold
  // the other's pin low.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      intExpansion_n_q <= `PIA_INT_N_RESET;
    end
    else
    begin
      intExpansion_n_q <= ~(|expIrqPending);
    end
  end

  assign intProtocol_n_o = 1'b0;
  assign intProtocol_n_oe = ~intProtocol_n_q;
  assign intExpansion_n_o = 1'b0;
  assign intExpansion_n_oe = ~intExpansion_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus mastering: request, wait for grant, then frame until the last phase.
  pia_pkg::pia_master_state_type state_q;
  logic busRequest_n_q;
  logic frame_n_q;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q <= pia_pkg::MS_IDLE;
    end
    else
    begin
      case (state_q)
        pia_pkg::MS_IDLE:
        begin
          if (masterWant)
          begin
            state_q <= pia_pkg::MS_REQUEST;
          end
        end
        pia_pkg::MS_REQUEST:
        begin
          if (!masterWant)
          begin
            state_q <= pia_pkg::MS_IDLE;
          end
          else if (!grantSync)
          begin
            state_q <= pia_pkg::MS_FRAME;
          end
        end
        pia_pkg::MS_FRAME:
        begin
          // Frame is held until the final phase is flagged.
          if (masterLast)
          begin
            state_q <= pia_pkg::MS_IDLE;
          end
        end
        default:
        begin
          state_q <= pia_pkg::MS_IDLE;
        end
      endcase
    end
  end

  // The request is dropped on the edge that starts the frame, so the arbiter
  // is free to move the grant on while this cycle runs.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      busRequest_n_q <= `PIA_REQ_N_RESET;
    end
    else
    begin
      case (state_q)
        pia_pkg::MS_IDLE:
        begin
          busRequest_n_q <= ~masterWant;
        end
        pia_pkg::MS_REQUEST:
        begin
          busRequest_n_q <= ~masterWant | ~grantSync;
        end
        default:
        begin
          busRequest_n_q <= 1'b1;
        end
      endcase
    end
  end

  // Frame falls on the edge that takes the grant and rises on the edge that
  // sees the last phase. The grant seen here is two cycles old, which is the
  // price of passing the pin through the synchroniser.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      frame_n_q <= `PIA_FRAME_N_RESET;
    end
    else
    begin
      case (state_q)
        pia_pkg::MS_REQUEST:
        begin
          frame_n_q <= ~(masterWant & ~grantSync);
        end
        pia_pkg::MS_FRAME:
        begin
          frame_n_q <= masterLast;
        end
        default:
        begin
          frame_n_q <= 1'b1;
        end
      endcase
    end
  end

  assign busRequest_n = busRequest_n_q;
  assign frame_n_o = frame_n_q;
  assign frame_n_oe = (state_q == pia_pkg::MS_FRAME);
  assign masterActive = (state_q == pia_pkg::MS_FRAME);

  ////////////////////////////////////////////////////////////////////////////
  // Expansion clock: an enable on clk_sys, every cycle or every second one.
  // An enable avoids a derived clock and the skew it would bring.
  logic div_q;
  logic clkEn_q;
  logic halfRate_q;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      div_q <= `PIA_DIV_RESET;
      clkEn_q <= `PIA_CLK_EN_RESET;
      halfRate_q <= `PIA_SEL_RESET;
    end
    else
    begin
      div_q <= ~div_q;
      halfRate_q <= halveSync;
      if (halveSync)
      begin
        clkEn_q <= div_q;
      end
      else
      begin
        clkEn_q <= 1'b1;
      end
    end
  end

  assign expansion_bus_clock_en = clkEn_q;
  assign expansionHalfRate = halfRate_q;
endmodule : pia_sideband
`default_nettype wire

// ==== tb/pia_arbiter_model.sv ====
// Bus arbiter model that grants after a chosen delay.
`timescale 1ns/1ps
`default_nettype none
module pia_arbiter_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic busRequest_n,
  input wire logic masterActive,
  input wire logic [2:0] grantDelay,
  output logic busGrant_n
);
  logic [2:0] wait_q;
  // Grant is held through the owned cycle, so a frame never starts on a lapsed grant.
  always_ff @(posedge clk_sys)
  begin
    if (reset || (busRequest_n && !masterActive))
    begin
      busGrant_n <= 1'b1;
      wait_q <= 3'h0;
    end
    else if (wait_q == grantDelay)
      busGrant_n <= 1'b0;
    else
      wait_q <= wait_q + 3'h1;
  end
endmodule : pia_arbiter_model
`default_nettype wire

// ==== tb/pia_sideband_assertions.sv ====
// Checker for the PCI sideband block.
`timescale 1ns/1ps
`default_nettype none
module pia_sideband_assertions #(
  parameter int L2_SOURCES = 8,
  parameter int EXP_SOURCES = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [L2_SOURCES-1:0] l2IrqPending,
  input wire logic [EXP_SOURCES-1:0] expIrqPending,
  input wire logic intProtocol_n_oe,
  input wire logic intExpansion_n_oe,
  input wire logic masterWant,
  input wire logic masterLast,
  input wire logic busRequest_n,
  input wire logic busGrant_n,
  input wire logic frame_n_o,
  input wire logic frame_n_oe,
  input wire logic masterActive,
  input wire logic expansion_bus_clock_en,
  input wire logic expansionHalfRate
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_int_proto: assert property (!reset && |l2IrqPending |=> intProtocol_n_oe)
    else $error("int1");
  chk_int_exp: assert property (!reset && |expIrqPending |=> intExpansion_n_oe)
    else $error("int2");
  chk_int_release: assert property (!(|l2IrqPending) && !(|expIrqPending) |=>
    !intProtocol_n_oe && !intExpansion_n_oe) else $error("int hold");
  chk_req_rise: assert property ($rose(masterWant) && !masterActive |=> !busRequest_n)
    else $error("req");
  chk_frame_grant: assert property ($rose(frame_n_oe) |-> !frame_n_o && !$past(busGrant_n, 3))
    else $error("frame");
  chk_frame_hold: assert property (frame_n_oe && !masterLast |=> frame_n_oe && !frame_n_o)
    else $error("hold");
  chk_frame_end: assert property (frame_n_oe && masterLast |=> frame_n_o && !frame_n_oe)
    else $error("end");
  chk_clk_full: assert property (!expansionHalfRate [*3] |-> expansion_bus_clock_en)
    else $error("full");
  chk_clk_half: assert property (expansionHalfRate [*3] |->
    expansion_bus_clock_en != $past(expansion_bus_clock_en)) else $error("half");
  cov_frame: cover property ($rose(masterActive));
  cov_half: cover property (expansionHalfRate && expansion_bus_clock_en);
  cov_both: cover property (intProtocol_n_oe && intExpansion_n_oe);
endmodule : pia_sideband_assertions
bind pia_sideband pia_sideband_assertions #(
  .L2_SOURCES(L2_SOURCES),
  .EXP_SOURCES(EXP_SOURCES)
) chk (
  .clk_sys(clk_sys),
  .reset(reset),
  .l2IrqPending(l2IrqPending),
  .expIrqPending(expIrqPending),
  .intProtocol_n_oe(intProtocol_n_oe),
  .intExpansion_n_oe(intExpansion_n_oe),
  .masterWant(masterWant),
  .masterLast(masterLast),
  .busRequest_n(busRequest_n),
  .busGrant_n(busGrant_n),
  .frame_n_o(frame_n_o),
  .frame_n_oe(frame_n_oe),
  .masterActive(masterActive),
  .expansion_bus_clock_en(expansion_bus_clock_en),
  .expansionHalfRate(expansionHalfRate)
);
`default_nettype wire

// ==== tb/pia_sideband_tb.sv ====
// Self-checking bench for the PCI sideband block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin nMismatch++; \
  $display("ERROR %0t %h %h", $time, a, b); end end
module pia_sideband_tb;
  logic clk_sys = 1'b0, reset = 1'b1, want = 1'b0, last = 1'b0, sel = 1'b0;
  logic [7:0] l2Pend = 8'h00;
  logic [3:0] expPend = 4'h0;
  logic [2:0] dly = 3'h0;
  logic enPrev;
  logic p1o, p1oe, p2o, p2oe, reqN, gntN, frN, frOe, act, en, half;
  int nMismatch = 0, checked = 0, i;
  logic [31:0] rng = 32'hc415;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // Each interrupt pin is wanted while any of its own sources pends.
  function automatic logic [1:0] int_expect(input logic [7:0] l2, input logic [3:0] ex);
    return {|l2, |ex};
  endfunction : int_expect
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", nMismatch, checked);
    if (nMismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  pia_sideband uut (.clk_sys, .reset, .l2IrqPending(l2Pend), .expIrqPending(expPend),
    .intProtocol_n_o(p1o), .intProtocol_n_oe(p1oe), .intExpansion_n_o(p2o),
    .intExpansion_n_oe(p2oe), .masterWant(want), .masterLast(last), .busRequest_n(reqN),
    .busGrant_n(gntN), .frame_n_o(frN), .frame_n_oe(frOe), .masterActive(act),
    .expansion_clock_halve_select(sel), .expansion_bus_clock_en(en), .expansionHalfRate(half));
  pia_arbiter_model arb (.clk_sys, .reset, .busRequest_n(reqN), .masterActive(act),
    .grantDelay(dly), .busGrant_n(gntN));
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #50us;
    nMismatch++;
    end_of_test();
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    // Zero vectors are forced now and then so the release path is exercised.
    repeat (150)
    begin
      rng = xs(rng);
      l2Pend <= rng[1:0] == 2'h0 ? 8'h00 : rng[15:8];
      expPend <= rng[19:16] & {4{rng[20]}};
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK({p1oe, p2oe}, int_expect(l2Pend, expPend))
      `CHK({p1o, p2o}, 2'h0)
      @(posedge clk_sys);
    end
    // The divider runs freely, so half rate is checked by its alternation,
    // not by a fixed phase.
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      sel <= i[0];
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      enPrev = en;
      `CHK(half, i[0])
      @(negedge clk_sys);
      `CHK({enPrev, en}, i[0] ? {enPrev, ~enPrev} : 2'h3)
      @(negedge clk_sys);
      `CHK(en, enPrev)
    end
    // Reset in mid-run, in half rate and with interrupts possibly pending.
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK({p1oe, p2oe, reqN, frN, frOe, act, en, half}, 8'h30)
    @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    repeat (8)
    begin
      rng = xs(rng);
      @(posedge clk_sys);
      dly <= rng[2:0];
      want <= 1'b1;
      @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK(reqN, 1'b0)
      for (i = 0; i < 20 && act !== 1'b1; i++) @(negedge clk_sys);
      `CHK({act, frN, reqN}, 3'h5)
      repeat (int'(rng[4:3]) + 1) @(posedge clk_sys);
      last <= 1'b1;
      want <= 1'b0;
      @(posedge clk_sys);
      last <= 1'b0;
      @(negedge clk_sys);
      `CHK({frOe, frN}, 2'h1)
      repeat (4) @(posedge clk_sys);
    end
    end_of_test();
  end
endmodule : pia_sideband_tb
`default_nettype wire
